// file: design/pause_frame_tx_flow_control.sv
// Transmit flow control: decides when to send XOFF and XON pause frames
// and emits their bytes, destination address to pad, one byte per beat.
// Assumes the downstream framer adds preamble and FCS, that the data path
// reports its frames and honours dataTxHold_q and gapOpen_q before starting.
`default_nettype none

module pause_frame_tx_flow_control #(
  parameter int GAP_EXT_W = pause_fc_pkg::GAP_EXT_W
) (
  input  wire logic                             clk,
  input  wire logic                             resetn,
  input  wire logic                             txPauseEnable,
  input  wire logic                             xonSendEnable,
  input  wire logic                             rxFlowEnable,
  input  wire pause_fc_pkg::fc_marks_t          marks,
  input  wire logic [pause_fc_pkg::TIMER_W-1:0] txPauseTimeValue,
  input  wire logic [pause_fc_pkg::TIMER_W-1:0] pauseRefreshThreshold,
  input  wire logic [pause_fc_pkg::TH_W-1:0]    rxFullness,
  input  wire logic                             rxOverflow,
  input  wire logic                             swPauseSet,
  input  wire logic                             dmaCoalesceEnable,
  input  wire logic                             dmaCoalesceActive,
  input  wire logic                             txBufferEmpty,
  input  wire logic [GAP_EXT_W-1:0]             gapExtension,
  input  wire logic [1:0]                       lineSpeed,
  input  wire logic [47:0]                      stationAddress,
  input  wire logic                             dataFrameActive,
  input  wire logic                             dataFrameEnd,
  input  wire logic                             rxControlFrameSeen,
  output pause_fc_pkg::tx_byte_t                txStream_q,
  output logic                                  dataTxHold_q,
  output logic                                  gapOpen_q,
  output logic                                  swPauseRequest_q,
  output logic                                  xoffActive_q,
  output logic                                  rxCountAsOrdinary_q
);

  initial begin
    if (GAP_EXT_W < 1 || GAP_EXT_W > pause_fc_pkg::GAP_EXT_W) begin
      $error("gap extension width out of range");
    end
  end

  pause_fc_pkg::tx_state_t            state_q, state_d;
  pause_fc_pkg::frame_kind_t          curKind_q, curKind_d, selKind;
  pause_fc_pkg::tx_byte_t             txStream_d;
  logic [pause_fc_pkg::IDX_W-1:0]     idx_q, idx_d;
  logic [pause_fc_pkg::TIMER_W-1:0]   timeField_q, timeField_d;
  logic [pause_fc_pkg::GAP_CNT_W-1:0] gapCnt_q, gapCnt_d, gapLoad;
  logic [pause_fc_pkg::CPB_W-1:0]     cyclesPerByte;
  logic [pause_fc_pkg::TH_W-1:0]      effHigh;
  logic [pause_fc_pkg::TIMER_W-1:0]   shadowCount;
  logic xoffPend_q, xoffPend_d, xonPend_q, xonPend_d;
  logic swPauseRequest_d, xoffActive_d, ovfUsed_q, ovfUsed_d;
  logic dataTxHold_d, gapOpen_d, rxCountAsOrdinary_d;
  logic above, atLow, startFrame, lastByte;
  logic timerLoad, timerStop, shadowRunning, refreshHit, shadowExpired;

  // Byte of the pause frame at a given offset.
  function automatic logic [7:0] frameByte(
    input logic [pause_fc_pkg::IDX_W-1:0]   i,
    input logic [47:0]                      sa,
    input logic [pause_fc_pkg::TIMER_W-1:0] tf
  );
    int k;
    k = int'(i);
    if (i < pause_fc_pkg::OFS_SA) begin
      frameByte = pause_fc_pkg::CTRL_DA[
        8*(int'(pause_fc_pkg::OFS_SA)-1-k)+:8];
    end else if (i < pause_fc_pkg::OFS_TYPE) begin
      frameByte = sa[8*(int'(pause_fc_pkg::OFS_TYPE)-1-k)+:8];
    end else if (i < pause_fc_pkg::OFS_OPC) begin
      frameByte = pause_fc_pkg::CTRL_TYPE[
        8*(int'(pause_fc_pkg::OFS_OPC)-1-k)+:8];
    end else if (i < pause_fc_pkg::OFS_TIME) begin
      frameByte = pause_fc_pkg::PAUSE_OPC[
        8*(int'(pause_fc_pkg::OFS_TIME)-1-k)+:8];
    end else if (i < pause_fc_pkg::OFS_PAD) begin
      frameByte = tf[8*(int'(pause_fc_pkg::OFS_PAD)-1-k)+:8];
    end else begin
      frameByte = pause_fc_pkg::PAD_BYTE;
    end
  endfunction

  // Line rate to clock cycles per byte, and the watermark comparisons.
  always_comb begin
    unique case (lineSpeed)
      pause_fc_pkg::SPEED_100: cyclesPerByte = 7'(pause_fc_pkg::CPB_100);
      pause_fc_pkg::SPEED_10:  cyclesPerByte = 7'(pause_fc_pkg::CPB_10);
      default:                 cyclesPerByte = 7'(pause_fc_pkg::CPB_1000);
    endcase
    effHigh = (dmaCoalesceEnable && dmaCoalesceActive && txBufferEmpty) ?
              marks.coalesceHigh : marks.high;
    above = (rxFullness > effHigh);
    atLow = (rxFullness <= marks.low);
  end

  // Base gap plus the extension in four-byte steps, scaled to the rate.
  assign gapLoad = pause_fc_pkg::GAP_CNT_W'(
    (pause_fc_pkg::IPG_BYTES + pause_fc_pkg::GAP_STEP_BYTES *
     int'(gapExtension)) * int'(cyclesPerByte));

  // Pending requests, frame start selection and the byte sequencer.
  always_comb begin
    xoffPend_d       = xoffPend_q;
    xonPend_d        = xonPend_q;
    ovfUsed_d        = ovfUsed_q;
    xoffActive_d     = xoffActive_q;
    swPauseRequest_d = swPauseRequest_q;
    state_d          = state_q;
    curKind_d        = curKind_q;
    idx_d            = idx_q;
    timeField_d      = timeField_q;
    txStream_d       = '0;
    timerLoad        = 1'b0;
    timerStop        = 1'b0;
    selKind          = pause_fc_pkg::KIND_HW;
    lastByte         = (state_q == pause_fc_pkg::ST_SEND) &&
                       (idx_q == pause_fc_pkg::FRAME_LAST);
    // Hardware triggers are dropped entirely while the enable is off.
    if (!txPauseEnable) begin
      xoffPend_d   = 1'b0;
      xonPend_d    = 1'b0;
      xoffActive_d = 1'b0;
    end else begin
      if (above && !xoffActive_q) begin
        xoffPend_d = 1'b1;
      end
      if (refreshHit && xoffActive_q && above) begin
        xoffPend_d = 1'b1;
      end
      if (rxOverflow && xoffActive_q && !ovfUsed_q) begin
        xoffPend_d = 1'b1;
        ovfUsed_d  = 1'b1;
      end
      if (xonSendEnable && xoffActive_q && atLow && !above) begin
        xonPend_d = 1'b1;
      end
      if (shadowExpired) begin
        xoffActive_d = 1'b0;
      end
    end
    // A frame starts only between data frames, once the gap has run out.
    startFrame = (state_q == pause_fc_pkg::ST_IDLE) && !dataFrameActive &&
                 gapOpen_q && (((xoffPend_q || xonPend_q) && txPauseEnable)
                 || swPauseRequest_q);
    if (xoffPend_q && txPauseEnable) begin
      selKind = pause_fc_pkg::KIND_HW;
    end else if (swPauseRequest_q) begin
      selKind = pause_fc_pkg::KIND_SW;
    end else begin
      selKind = pause_fc_pkg::KIND_XON;
    end
    if (startFrame) begin
      state_d   = pause_fc_pkg::ST_SEND;
      curKind_d = selKind;
      idx_d     = '0;
      unique case (selKind)
        pause_fc_pkg::KIND_HW: begin
          timeField_d  = txPauseTimeValue;
          xoffPend_d   = 1'b0;
          xonPend_d    = 1'b0;
          xoffActive_d = 1'b1;
          timerLoad    = 1'b1;
        end
        pause_fc_pkg::KIND_XON: begin
          timeField_d  = '0;
          xonPend_d    = 1'b0;
          xoffActive_d = 1'b0;
          ovfUsed_d    = 1'b0;
          timerStop    = 1'b1;
        end
        pause_fc_pkg::KIND_SW: begin
          timeField_d = txPauseTimeValue;
        end
      endcase
    end
    if (state_q == pause_fc_pkg::ST_SEND) begin
      txStream_d.valid = 1'b1;
      txStream_d.last  = lastByte;
      txStream_d.data  = frameByte(idx_q, stationAddress,
                                   timeField_q);
      idx_d = idx_q + 1'b1;
      if (lastByte) begin
        state_d = pause_fc_pkg::ST_IDLE;
        if (curKind_q == pause_fc_pkg::KIND_SW) begin
          swPauseRequest_d = 1'b0;
        end
      end
    end
    if (swPauseSet) begin
      swPauseRequest_d = 1'b1;
    end
  end

  // Gap timer, hold towards the data path, and receive classification.
  always_comb begin
    gapCnt_d = gapCnt_q;
    if (dataFrameEnd || lastByte) begin
      gapCnt_d = gapLoad;
    end else if (gapCnt_q != '0) begin
      gapCnt_d = gapCnt_q - 1'b1;
    end
    gapOpen_d = (gapCnt_d == '0) && !dataFrameActive;
    dataTxHold_d = (state_d == pause_fc_pkg::ST_SEND) || xoffPend_d ||
                   xonPend_d || swPauseRequest_d;
    rxCountAsOrdinary_d = rxControlFrameSeen && !rxFlowEnable;
  end

  pause_quanta_timer u_shadow (
    .clk           (clk),
    .resetn        (resetn),
    .load          (timerLoad),
    .loadValue     (txPauseTimeValue),
    .stop          (timerStop),
    .threshold     (pauseRefreshThreshold),
    .cyclesPerByte (cyclesPerByte),
    .count_q       (shadowCount),
    .running_q     (shadowRunning),
    .reached_q     (refreshHit),
    .expired_q     (shadowExpired)
  );

  // Registers all state of the block.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q             <= pause_fc_pkg::ST_IDLE;
      curKind_q           <= pause_fc_pkg::KIND_HW;
      idx_q               <= '0;
      timeField_q         <= '0;
      txStream_q          <= '0;
      xoffPend_q          <= 1'b0;
      xonPend_q           <= 1'b0;
      ovfUsed_q           <= 1'b0;
      xoffActive_q        <= 1'b0;
      swPauseRequest_q    <= 1'b0;
      gapCnt_q            <= '0;
      gapOpen_q           <= 1'b1;
      dataTxHold_q        <= 1'b0;
      rxCountAsOrdinary_q <= 1'b0;
    end else begin
      state_q             <= state_d;
      curKind_q           <= curKind_d;
      idx_q               <= idx_d;
      timeField_q         <= timeField_d;
      txStream_q          <= txStream_d;
      xoffPend_q          <= xoffPend_d;
      xonPend_q           <= xonPend_d;
      ovfUsed_q           <= ovfUsed_d;
      xoffActive_q        <= xoffActive_d;
      swPauseRequest_q    <= swPauseRequest_d;
      gapCnt_q            <= gapCnt_d;
      gapOpen_q           <= gapOpen_d;
      dataTxHold_q        <= dataTxHold_d;
      rxCountAsOrdinary_q <= rxCountAsOrdinary_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_hwStart;
    startFrame && selKind == pause_fc_pkg::KIND_HW;
  endsequence

  // Checks on frame contents, timing and request handling.
  a_hw_needs_enable: assert property (
    startFrame && selKind != pause_fc_pkg::KIND_SW |-> txPauseEnable)
    else $error("hardware pause started without enable");
  a_xoff_time: assert property (
    s_hwStart |=> timeField_q == $past(txPauseTimeValue))
    else $error("xoff time field wrong");
  a_shadow_load: assert property (
    s_hwStart |=> shadowCount == $past(txPauseTimeValue))
    else $error("shadow timer not restarted");
  a_xon_zero: assert property (
    startFrame && selKind == pause_fc_pkg::KIND_XON |=> timeField_q == '0)
    else $error("xon time not zero");
  a_frame_len: assert property (
    $rose(txStream_q.valid) |-> txStream_q.data == 8'h01
    ##59 txStream_q.last)
    else $error("pause frame length or address wrong");
  a_sw_clear: assert property (
    lastByte && curKind_q == pause_fc_pkg::KIND_SW && !swPauseSet
    |=> !swPauseRequest_q)
    else $error("software request not cleared");
  a_sw_no_enable: assert property (
    swPauseRequest_q && state_q == pause_fc_pkg::ST_IDLE &&
    !dataFrameActive && gapOpen_q |-> startFrame)
    else $error("software pause not started");
  a_gap_wait: assert property (
    startFrame |-> !dataFrameActive && gapOpen_q)
    else $error("pause started inside frame or gap");
  a_gap_closed: assert property (
    dataFrameEnd |=> !gapOpen_q)
    else $error("gap not closed after frame");
  a_coal_mark: assert property (
    dmaCoalesceEnable && dmaCoalesceActive && txBufferEmpty
    |-> effHigh == marks.coalesceHigh)
    else $error("coalescing watermark not used");

endmodule // pause_frame_tx_flow_control

`default_nettype wire

// file: design/pause_fc_pkg.sv
// Constants, field layouts and carrier types of the pause transmit block.
// Assumes one 125 MHz clock that moves one line byte per cycle at 1 Gb/s.
// Notes on behaviour
// - Hardware pause frames need the transmit enable.
// - Above high watermark send XOFF with time.
// - Shadow timer reaching threshold resends XOFF.
// - At low watermark, with XON enabled, send XON.
// - Overflow after XOFF sends one more pause.
// - Coalescing with empty transmit buffer uses alternate watermark.
// - Software request sends a pause frame.
// - Software request bit clears after its frame.
// - Software frames never arm the refresh timer.
// - Software frames ignore enable and negotiation.
// - Flow control off: pause frames are ordinary.
// - Gap lengthened in steps of four bytes.
// - Frames use control address, type and opcode.
// - Timers count quanta of 512 bit times.
`default_nettype none

package pause_fc_pkg;

  localparam int TH_W        = 13;
  localparam int TIMER_W     = 16;
  localparam int GAP_EXT_W   = 10;
  localparam int IDX_W       = 6;
  localparam int PRE_W       = 13;
  localparam int GAP_CNT_W   = 20;
  localparam int CPB_W       = 7;

  // Frame layout, byte offsets from the first destination byte.
  localparam logic [IDX_W-1:0] OFS_SA      = 6'h06;
  localparam logic [IDX_W-1:0] OFS_TYPE    = 6'h0C;
  localparam logic [IDX_W-1:0] OFS_OPC     = 6'h0E;
  localparam logic [IDX_W-1:0] OFS_TIME    = 6'h10;
  localparam logic [IDX_W-1:0] OFS_PAD     = 6'h12;
  localparam logic [IDX_W-1:0] FRAME_LAST  = 6'h3B;
  localparam logic [47:0]      CTRL_DA     = 48'h0180C2000001;
  localparam logic [15:0]      CTRL_TYPE   = 16'h8808;
  localparam logic [15:0]      PAUSE_OPC   = 16'h0001;
  localparam logic [7:0]       PAD_BYTE    = 8'h00;

  // Line timing.
  localparam int CLK_PERIOD_NS    = 8;
  localparam int BYTE_TIME_1G_NS  = 8;
  localparam int CPB_1000 = BYTE_TIME_1G_NS / CLK_PERIOD_NS;
  localparam int CPB_100  = (BYTE_TIME_1G_NS * 10) / CLK_PERIOD_NS;
  localparam int CPB_10   = (BYTE_TIME_1G_NS * 100) / CLK_PERIOD_NS;
  localparam int QUANTUM_BYTES    = 64;
  localparam int IPG_BYTES        = 12;
  localparam int GAP_STEP_BYTES   = 4;

  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    KIND_HW  = 3'b001,
    KIND_XON = 3'b010,
    KIND_SW  = 3'b100
  } frame_kind_t;

  typedef struct packed {
    logic            valid;
    logic            last;
    logic [7:0]      data;
  } tx_byte_t;

  typedef struct packed {
    logic [TH_W-1:0] high;
    logic [TH_W-1:0] coalesceHigh;
    logic [TH_W-1:0] low;
  } fc_marks_t;

endpackage

`default_nettype wire

// file: design/pause_quanta_timer.sv
// Shadow of the link partner's pause timer, counted in pause quanta.
// Assumes the caller supplies the clock cycles per line byte.
`default_nettype none

module pause_quanta_timer (
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic                                load,
  input  wire logic [pause_fc_pkg::TIMER_W-1:0]    loadValue,
  input  wire logic                                stop,
  input  wire logic [pause_fc_pkg::TIMER_W-1:0]    threshold,
  input  wire logic [pause_fc_pkg::CPB_W-1:0]      cyclesPerByte,
  output logic      [pause_fc_pkg::TIMER_W-1:0]    count_q,
  output logic                                     running_q,
  output logic                                     reached_q,
  output logic                                     expired_q
);

  logic [pause_fc_pkg::PRE_W-1:0]   pre_q, pre_d;
  logic [pause_fc_pkg::PRE_W-1:0]   quantumCycles;
  logic [pause_fc_pkg::TIMER_W-1:0] count_d;
  logic                             running_d, reached_d, expired_d;

  // One quantum is 64 byte times at the current line rate.
  assign quantumCycles = pause_fc_pkg::PRE_W'(
    pause_fc_pkg::QUANTUM_BYTES * int'(cyclesPerByte));

  // Counts down one quantum at a time; a load restarts, stop halts.
  always_comb begin
    pre_d     = pre_q;
    count_d   = count_q;
    running_d = running_q;
    reached_d = 1'b0;
    expired_d = 1'b0;
    if (load) begin
      count_d   = loadValue;
      running_d = (loadValue != '0);
      pre_d     = '0;
    end else if (stop) begin
      running_d = 1'b0;
    end else if (running_q) begin
      if (pre_q == quantumCycles - 1'b1) begin
        pre_d   = '0;
        count_d = count_q - 1'b1;
        reached_d = (count_d == threshold);
        if (count_d == '0) begin
          running_d = 1'b0;
          expired_d = 1'b1;
        end
      end else begin
        pre_d = pre_q + 1'b1;
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q     <= '0;
      count_q   <= '0;
      running_q <= 1'b0;
      reached_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      pre_q     <= pre_d;
      count_q   <= count_d;
      running_q <= running_d;
      reached_q <= reached_d;
      expired_q <= expired_d;
    end
  end

endmodule // pause_quanta_timer

`default_nettype wire

// file: test/link_partner_model.sv
// Link partner model: receives pause frames and checks their layout.
// Assumes one byte per clock on the stream with no back-pressure.
`default_nettype none

module link_partner_model (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire pause_fc_pkg::tx_byte_t rxByte,
  input  wire logic [47:0]            stationAddress,
  output logic      [7:0]             frameCnt,
  output logic      [15:0]            lastTime,
  output logic                        frameOk
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [127:0] hdr;
  logic [6:0]   idx;
  logic         good;

  // Expected header: control address, source, type and opcode.
  assign hdr = {pause_fc_pkg::CTRL_DA, stationAddress,
                pause_fc_pkg::CTRL_TYPE, pause_fc_pkg::PAUSE_OPC};

  // Collects each frame byte and judges it when the last byte arrives.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx <= 7'h00;
      frameCnt <= 8'h00;
      lastTime <= 16'h0000;
      frameOk <= 1'b0;
      good <= 1'b1;
    end else if (rxByte.valid === 1'b1) begin
      if (idx < 7'h10) begin
        if (rxByte.data !== hdr[127-8*idx -: 8]) good <= 1'b0;
      end else if (idx == 7'h10) begin
        lastTime[15:8] <= rxByte.data;
      end else if (idx == 7'h11) begin
        lastTime[7:0] <= rxByte.data;
      end else if (rxByte.data !== pause_fc_pkg::PAD_BYTE) begin
        good <= 1'b0;
      end
      idx <= idx + 7'h01;
      if (rxByte.last === 1'b1) begin
        frameOk <= good && (idx == 7'h3B) &&
                   (rxByte.data === pause_fc_pkg::PAD_BYTE);
        frameCnt <= frameCnt + 8'h01;
        idx <= 7'h00;
        good <= 1'b1;
      end
    end
  end
endmodule // link_partner_model

`default_nettype wire

// file: test/pause_frame_tx_flow_control_tb.sv
// Self-checking bench of the pause transmit block with a receiving partner.
// Runs at the 1 Gb/s rate, one byte per 8 ns clock, except for a last gap check at 100 Mb/s.
`default_nettype none

module pause_frame_tx_flow_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic txPauseEnable = 1'b0; // Full-duplex link only
  logic xonSendEnable = 1'b0;
  logic rxFlowEnable = 1'b1;
  logic rxOverflow = 1'b0;
  logic swPauseSet = 1'b0;
  logic dmaCoalesceEnable = 1'b0;
  logic dmaCoalesceActive = 1'b0;
  logic txBufferEmpty = 1'b0;
  logic dataFrameActive = 1'b0;
  logic dataFrameEnd = 1'b0;
  logic rxControlFrameSeen = 1'b0;
  // Watermarks kept inside the advised bounds
  pause_fc_pkg::fc_marks_t marks = '{13'h0064, 13'h00C8, 13'h0014};
  logic [15:0] txPauseTimeValue = 16'h0004; // Never zero
  logic [15:0] pauseRefreshThreshold = 16'h0002;
  logic [12:0] rxFullness = 13'h000A;
  logic [9:0]  gapExtension = 10'h000;
  logic [1:0]  lineSpeed = pause_fc_pkg::SPEED_1000;
  logic [47:0] stationAddress = 48'h0A1B2C3D4E5F;
  pause_fc_pkg::tx_byte_t txStream_q;
  logic dataTxHold_q, gapOpen_q, swPauseRequest_q;
  logic xoffActive_q, rxCountAsOrdinary_q, frameOk;
  logic [7:0]  frameCnt;
  logic [15:0] lastTime;
  int error_cnt = 0;
  int cmp_count = 0;
  int k, g;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  pause_frame_tx_flow_control u_dut (
    .clk(clk), .resetn(resetn), .txPauseEnable(txPauseEnable),
    .xonSendEnable(xonSendEnable), .rxFlowEnable(rxFlowEnable),
    .marks(marks), .txPauseTimeValue(txPauseTimeValue),
    .pauseRefreshThreshold(pauseRefreshThreshold),
    .rxFullness(rxFullness), .rxOverflow(rxOverflow),
    .swPauseSet(swPauseSet), .dmaCoalesceEnable(dmaCoalesceEnable),
    .dmaCoalesceActive(dmaCoalesceActive),
    .txBufferEmpty(txBufferEmpty), .gapExtension(gapExtension),
    .lineSpeed(lineSpeed), .stationAddress(stationAddress),
    .dataFrameActive(dataFrameActive), .dataFrameEnd(dataFrameEnd),
    .rxControlFrameSeen(rxControlFrameSeen), .txStream_q(txStream_q),
    .dataTxHold_q(dataTxHold_q), .gapOpen_q(gapOpen_q),
    .swPauseRequest_q(swPauseRequest_q), .xoffActive_q(xoffActive_q),
    .rxCountAsOrdinary_q(rxCountAsOrdinary_q)
  );

  link_partner_model u_partner (
    .clk(clk), .resetn(resetn), .rxByte(txStream_q),
    .stationAddress(stationAddress), .frameCnt(frameCnt),
    .lastTime(lastTime), .frameOk(frameOk)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Counts one comparison and reports it when it failed.
  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Waits for the partner to hold n frames; k gets the cycles spent.
  task automatic waitf(input int n);
    k = 0;
    while (frameCnt < n && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) begin
      chk(1'b0, "frame wait timed out");
      results();
    end
  endtask

  // Drives a one-cycle pulse on a request input.
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Main sequence, all inputs changed at the falling edge.
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    rxFullness = 13'h0096;
    repeat (20) @(negedge clk);
    chk(frameCnt === 8'h00, "frame sent while disabled");
    pulse(swPauseSet);
    chk(swPauseRequest_q === 1'b1, "request bit not set");
    waitf(1);
    chk(lastTime === 16'h0004 && frameOk === 1'b1, "sw frame");
    repeat (2) @(negedge clk);
    chk(swPauseRequest_q === 1'b0, "request bit kept");
    repeat (400) @(negedge clk);
    chk(frameCnt === 8'h01 && xoffActive_q === 1'b0, "sw refresh");
    txPauseEnable = 1'b1;
    waitf(2);
    chk(lastTime === 16'h0004 && frameOk === 1'b1, "bad XOFF");
    chk(xoffActive_q === 1'b1, "XOFF not in force");
    waitf(3);
    chk(k >= 120 && k <= 140, "refresh timing");
    pulse(rxOverflow);
    waitf(4);
    chk(k < 100 && lastTime === 16'h0004, "no overflow pause");
    xonSendEnable = 1'b1;
    rxFullness = 13'h000A;
    waitf(5);
    chk(lastTime === 16'h0000 && frameOk === 1'b1, "bad XON");
    dmaCoalesceEnable = 1'b1;
    dmaCoalesceActive = 1'b1;
    txBufferEmpty = 1'b1;
    rxFullness = 13'h0096;
    repeat (200) @(negedge clk);
    chk(frameCnt === 8'h05, "normal mark used");
    rxFullness = 13'h00FA;
    waitf(6);
    chk(lastTime === 16'h0004, "no coalescing XOFF");
    rxFullness = 13'h000A;
    waitf(7);
    dmaCoalesceEnable = 1'b0;
    dmaCoalesceActive = 1'b0;
    gapExtension = 10'h002;
    dataFrameActive = 1'b1;
    rxFullness = 13'h0096;
    repeat (30) @(negedge clk);
    chk(frameCnt === 8'h07 && dataTxHold_q === 1'b1, "mid-frame");
    dataFrameActive = 1'b0;
    pulse(dataFrameEnd);
    g = 0;
    repeat (24) begin
      if (gapOpen_q === 1'b0) g++;
      @(negedge clk);
    end
    chk(g >= 20 && g <= 21, "gap length");
    waitf(8);
    chk(lastTime === 16'h0004 && frameOk === 1'b1, "late XOFF");
    rxFlowEnable = 1'b0;
    pulse(rxControlFrameSeen);
    chk(rxCountAsOrdinary_q === 1'b1, "not ordinary");
    rxFlowEnable = 1'b1;
    pulse(rxControlFrameSeen);
    chk(rxCountAsOrdinary_q === 1'b0, "counted while enabled");
    // At 100 Mb/s the base gap lasts ten clocks per byte.
    txPauseEnable = 1'b0;
    gapExtension = 10'h000;
    lineSpeed = pause_fc_pkg::SPEED_100;
    pulse(dataFrameEnd);
    g = 0;
    repeat (130) begin
      if (gapOpen_q === 1'b0) g++;
      @(negedge clk);
    end
    chk(g >= 120 && g <= 121, "gap at 100M");
    results();
  end
endmodule // pause_frame_tx_flow_control_tb

`default_nettype wire
